// ==== rtl/ips_defs.vh ====
`ifndef IPS_DEFS_VH
`define IPS_DEFS_VH
// register word indices; byte address is four times
`define IPS_ADR_CTRL     4'h0
`define IPS_ADR_SEL      4'h1
`define IPS_ADR_POL      4'h2
`define IPS_ADR_USER     4'h3
`define IPS_ADR_START    4'h4
`define IPS_ADR_COUNT    4'h5
`define IPS_ADR_STATUS   4'h6
`define IPS_ADR_IRQ_STAT 4'h7
`define IPS_ADR_IRQ_CLR  4'h8
`define IPS_ADR_IRQ_EN   4'h9
`define IPS_ADR_POS      4'ha
`define IPS_ADR_ERRCODE  4'hb
// field positions in ctrl
`define IPS_CTRL_SEL_EN  0
`define IPS_CTRL_TWO_EXP 1
// selector reset value and the fixed error code
`define IPS_SEL_RST      16'hffff
`define IPS_ERR_CODE     16'h1a6b
// selector codes
`define IPS_SEL_USER     4'h8
`define IPS_SEL_UNUSED   4'hf
// pulse timing: half period in clock cycles
`define IPS_HALF_PERIOD  16'h000a
`endif

// ==== rtl/ips_chan.v ====
`timescale 1ns/10ps
`include "ips_defs.vh"
// one pulse channel: waits for trigger, then emits a signed pulse count
module ips_chan (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        abort_i,
  input  wire [15:0] count_i,
  input  wire        trig_i,
  output reg         pulse_o,
  output reg         dir_o,
  output reg         busy_o,
  output reg         done_o,
  output reg         step_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg [2:0]  state_reg;
  reg [15:0] left_reg;
  reg [15:0] tick_reg;

  // ***************************************
  // sequencer
  // ***************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      left_reg  <= 16'h0000;
      tick_reg  <= 16'h0000;
      pulse_o   <= 1'b0;
      dir_o     <= 1'b0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      step_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      step_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_i && count_i != 16'h0000) begin
            dir_o    <= ~count_i[15];
            left_reg <= count_i[15] ? (16'h0000 - count_i) : count_i;
            busy_o   <= 1'b1;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (abort_i) begin
            busy_o    <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (trig_i) begin
            tick_reg  <= 16'h0000;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick_reg == `IPS_HALF_PERIOD - 16'h0001) begin
            tick_reg <= 16'h0000;
            pulse_o  <= ~pulse_o;
            if (pulse_o) begin
              left_reg <= left_reg - 16'h0001;
              step_o   <= 1'b1;
              if (left_reg == 16'h0001) begin
                done_o    <= 1'b1;
                busy_o    <= 1'b0;
                state_reg <= ST_IDLE;
              end
            end
          end else begin
            tick_reg <= tick_reg + 16'h0001;
          end
          // abort stops without completion, only while the pulse is low
          if (abort_i && !pulse_o) begin
            // the toggle above may raise the pulse in this very cycle:
            // force it low so an abort never leaves a pin stuck high
            pulse_o   <= 1'b0;
            busy_o    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/ips_top.v ====
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "ips_defs.vh"
// How it works
// - channel n drives direction output n
// - positive count: direction on, position increments
// - negative count: direction off, position decrements
// - selection off: channel n uses input n
// - selection on: channel digit picks source
// - digit 0 to 7 picks that input
// - digit 8 picks channel user command
// - digits 9 to e: error, no pulses
// - fourth channel needs two expansion modules
// - after trigger emit exact count, stop
// - count done sets execution complete flag
// - polarity bit inverts inputs, not user command
module ips_top #(
  parameter NCH = 4
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [5:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire [7:0]  ext_input_i,
  output wire [3:0]  pulse_out_o,
  output wire [3:0]  dir_out_o,
  output wire        irq_o
);

  // ***************************************
  // registers
  // ***************************************
  // register map, one 32-bit word per index, byte address is four times it:
  //   0  control: bit 0 source selection on, bit 1 fourth channel fitted
  //   1  source selector, one 4-bit digit per channel, channel 0 lowest
  //   2  trigger polarity invert, one bit per channel
  //   3  software trigger command, one bit per channel
  //   4  start (bits 3:0) and abort (bits 11:8), write only
  //   5  signed pulse count; bits 17:16 pick the channel on write and read
  //   6  status: busy 3:0, error 7:4, execution complete 8
  //   7  event status: bit 0 run complete, bit 1 start refused
  //   8  event clear, write one to clear; bits 7:4 clear the error bits
  //   9  event enable, same layout as event status
  //   a  position of the channel picked by bits 1:0, read only
  //   b  error code, read only
  // every other index reads zero and ignores writes; writes to read-only
  // words are acked and dropped
  // reset leaves every selector digit at f, so all channels start parked

  // software visible registers
  reg  [1:0]  ctrl_reg;
  reg  [15:0] sel_reg;
  reg  [3:0]  pol_reg;
  reg  [3:0]  user_reg;
  reg  [15:0] count_reg [0:3];
  // event and error bookkeeping
  reg  [3:0]  err_reg;
  reg  [1:0]  irq_stat_reg;
  reg  [1:0]  irq_en_reg;
  reg         exec_complete_flag_reg;
  // pin synchroniser, first and second stage
  reg  [7:0]  ext_meta_reg;
  reg  [7:0]  ext_sync_reg;

  // per channel handshakes from the sequencers
  wire [3:0]  busy_w;
  wire [3:0]  done_w;
  wire [3:0]  step_w;
  wire [3:0]  dir_w;
  wire [3:0]  trig_w;
  wire [3:0]  start_w;
  wire [3:0]  err_set_w;
  wire [3:0]  ch_ok_w;
  wire        wr_w;
  wire        rd_w;
  wire [3:0]  reg_idx_w;
  wire        start_wr_w;
  wire [127:0] pos_flat_w;
  wire        status_done_w;

  // a write lands on the edge at which the master sees ack high, never
  // earlier, so a master that gives up before the answer changes nothing
  assign wr_w       = cyc_i && stb_i && we_i && ack_o;
  // read data are fetched one edge early so they stand while ack is high
  assign rd_w       = cyc_i && stb_i && !we_i && !ack_o;
  assign reg_idx_w  = adr_i[5:2];
  assign start_wr_w = wr_w && reg_idx_w == `IPS_ADR_START && sel_i[0];

  // external inputs come from pins: two-flop synchroniser
  // only the second stage is read; the cost is two cycles of trigger
  // latency, on top of the one the sequencer needs to leave its wait state,
  // which is far below the pulse period and so harmless for positioning
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_meta_reg <= 8'h00;
      ext_sync_reg <= 8'h00;
    end else begin
      ext_meta_reg <= ext_input_i;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // ***************************************
  // per channel source select and sequencer
  // ***************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // selector digit meaning while selection is on:
      //   0..7  external input of that number, polarity applied
      //   8     software command bit of this channel, polarity ignored
      //   9..e  refused at start, error flagged, no pulses
      //   f     channel unused; software keeps it parked here
      // digit g of the selector
      wire [3:0] digit_w = sel_reg[4*g+3:4*g];
      wire       raw_w;
      wire       src_w;
      wire       bad_w;
      assign raw_w = ctrl_reg[`IPS_CTRL_SEL_EN] ? ext_sync_reg[digit_w[2:0]]
                                                 : ext_sync_reg[g];
      assign src_w = (ctrl_reg[`IPS_CTRL_SEL_EN] && digit_w == `IPS_SEL_USER)
                     ? user_reg[g] : (raw_w ^ pol_reg[g]);
      assign bad_w = ctrl_reg[`IPS_CTRL_SEL_EN] && digit_w > `IPS_SEL_USER &&
                     digit_w < `IPS_SEL_UNUSED;
      // fourth channel gated by module count
      // without the second expansion module a start of channel 3 is refused
      if (g == 3) begin : g_ok3
        assign ch_ok_w[g] = ctrl_reg[`IPS_CTRL_TWO_EXP];
      end else begin : g_ok
        assign ch_ok_w[g] = 1'b1;
      end
      // trigger is a level, sampled by the sequencer while it waits
      assign trig_w[g]    = src_w;
      assign err_set_w[g] = start_wr_w && dat_i[g] && (bad_w || !ch_ok_w[g]);
      // a busy channel ignores a second start until it finishes or aborts
      assign start_w[g]   = start_wr_w && dat_i[g] && !bad_w && ch_ok_w[g] &&
                            !busy_w[g];

      // abort bits sit in the second byte lane of the start word, so one
      // write can stop some channels and start others
      ips_chan u_chan (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (start_w[g]),
        .abort_i (wr_w && reg_idx_w == `IPS_ADR_START && sel_i[1] && dat_i[8+g]),
        .count_i (count_reg[g]),
        .trig_i  (trig_w[g]),
        .pulse_o (pulse_out_o[g]),
        .dir_o   (dir_w[g]),
        .busy_o  (busy_w[g]),
        .done_o  (done_w[g]),
        .step_o  (step_w[g])
      );

      assign dir_out_o[g] = dir_w[g];

      // position follows direction
      // each channel owns its counter, so no register has two writers;
      // the position is read only and only a finished pulse steps it
      reg [31:0] pos_reg;
      always @(posedge clk_i) begin
        if (rst_i) begin
          pos_reg <= 32'h0000_0000;
        end else if (step_w[g]) begin
          pos_reg <= dir_w[g] ? pos_reg + 32'h0000_0001
                              : pos_reg - 32'h0000_0001;
        end
      end
      assign pos_flat_w[32*g+31:32*g] = pos_reg;
    end
  endgenerate

  // ***************************************
  // register writes and events
  // ***************************************
  // count words reset to zero, which a start refuses to run
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg     <= 2'b00;
      sel_reg      <= `IPS_SEL_RST;
      pol_reg      <= 4'h0;
      user_reg     <= 4'h0;
      err_reg      <= 4'h0;
      irq_stat_reg <= 2'b00;
      irq_en_reg   <= 2'b00;
      for (i = 0; i < 4; i = i + 1) begin
        count_reg[i] <= 16'h0000;
      end
    end else begin
      // byte lanes are honoured for the wide registers; a count word goes
      // to the channel named in bits 17:16 of the same write
      if (wr_w) begin
        case (reg_idx_w)
          `IPS_ADR_CTRL: if (sel_i[0]) ctrl_reg <= dat_i[1:0];
          `IPS_ADR_SEL: begin
            if (sel_i[0]) sel_reg[7:0] <= dat_i[7:0];
            if (sel_i[1]) sel_reg[15:8] <= dat_i[15:8];
          end
          `IPS_ADR_POL: if (sel_i[0]) pol_reg <= dat_i[3:0];
          `IPS_ADR_USER: if (sel_i[0]) user_reg <= dat_i[3:0];
          `IPS_ADR_COUNT: begin
            if (sel_i[0]) count_reg[dat_i[17:16]][7:0] <= dat_i[7:0];
            if (sel_i[1]) count_reg[dat_i[17:16]][15:8] <= dat_i[15:8];
          end
          default: ;
        endcase
      end
      // clear first, then sets win in the same cycle
      if (wr_w && reg_idx_w == `IPS_ADR_IRQ_CLR && sel_i[0]) begin
        irq_stat_reg <= irq_stat_reg & ~dat_i[1:0];
        err_reg      <= err_reg & ~dat_i[7:4];
      end
      if (wr_w && reg_idx_w == `IPS_ADR_IRQ_EN && sel_i[0]) begin
        irq_en_reg <= dat_i[1:0];
      end
      // completion event, sticky until cleared; set beats a clear
      if (|done_w) begin
        irq_stat_reg[0] <= 1'b1;
      end
      // a refused start leaves the channel idle; the error bit says which
      // error flagged, channel not started
      if (|err_set_w) begin
        irq_stat_reg[1] <= 1'b1;
        err_reg <= ((wr_w && reg_idx_w == `IPS_ADR_IRQ_CLR && sel_i[0])
                    ? (err_reg & ~dat_i[7:4]) : err_reg) | err_set_w;
      end
    end
  end

  // level interrupt: high while an enabled event bit is set; masking an
  // event hides it from the pin but does not clear it
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // ***************************************
  // execution complete flag
  // ***************************************
  // a start write clears it and a finished run sets it; when both fall in
  // one cycle the finish wins, so a completion is never lost
  always @(posedge clk_i) begin
    if (rst_i) begin
      exec_complete_flag_reg <= 1'b0;
    end else if (|done_w) begin
      exec_complete_flag_reg <= 1'b1;
    end else if (start_wr_w) begin
      exec_complete_flag_reg <= 1'b0;
    end
  end

  // busy falls on the same edge that raises done, so the status word
  // folds done in and never shows a channel idle but not yet complete
  assign status_done_w = exec_complete_flag_reg | (|done_w);

  // ***************************************
  // wishbone read and ack, answered one cycle after the request
  // ***************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      // ack answers one cycle after the request and stands for one cycle;
      // a master that holds its request after ack gets a fresh cycle
      ack_o <= cyc_i && stb_i && !ack_o;
      // read data are loaded with the rising ack and hold until next read
      if (rd_w) begin
        case (reg_idx_w)
          `IPS_ADR_CTRL:     dat_o <= {30'h0, ctrl_reg};
          `IPS_ADR_SEL:      dat_o <= {16'h0, sel_reg};
          `IPS_ADR_POL:      dat_o <= {28'h0, pol_reg};
          `IPS_ADR_USER:     dat_o <= {28'h0, user_reg};
          `IPS_ADR_STATUS:   dat_o <= {23'h0, status_done_w, err_reg, busy_w};
          `IPS_ADR_IRQ_STAT: dat_o <= {30'h0, irq_stat_reg};
          `IPS_ADR_IRQ_EN:   dat_o <= {30'h0, irq_en_reg};
          `IPS_ADR_POS: begin
            // the channel to read rides on the low write data lines
            case (dat_i[1:0])
              2'b00:   dat_o <= pos_flat_w[31:0];
              2'b01:   dat_o <= pos_flat_w[63:32];
              2'b10:   dat_o <= pos_flat_w[95:64];
              default: dat_o <= pos_flat_w[127:96];
            endcase
          end
          `IPS_ADR_ERRCODE:  dat_o <= {16'h0, `IPS_ERR_CODE};
          `IPS_ADR_COUNT:    dat_o <= {16'h0, count_reg[dat_i[17:16]]};
          default:           dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== bench/ips_drive.sv ====
`timescale 1ns/10ps
// ****
// motor drive model
// ****
module ips_drive (
  input  wire logic       clk_i,
  input  wire logic [3:0] pulse_i,
  input  wire logic [3:0] dir_i,
  output wire logic [3:0][31:0] pos_o
);
  logic [3:0]       prev_reg = 4'h0;
  logic [3:0][31:0] pos_reg  = '0;
  assign pos_o = pos_reg;
  // direction pins are only read here, never driven
  always @(posedge clk_i) begin
    prev_reg <= pulse_i;
    for (int n = 0; n < 4; n++)
      if (prev_reg[n] && !pulse_i[n])
        pos_reg[n] <= pos_reg[n] + (dir_i[n] ? 32'h0000_0001 : 32'hffff_ffff);
  end
endmodule

// ==== bench/ips_check_assertions.sv ====
`timescale 1ns/10ps
// ****
// port checker
// ****
module ips_check (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [3:0]  pulse_out_o,
  input wire logic [3:0]  dir_out_o,
  input wire logic        irq_o
);
  // one domain, muted while reset is held, except the reset check
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_req = cyc_i && stb_i && !we_i && !ack_o;
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  errcode_read_a: assert property (rd_req && adr_i == 6'h2c |=> dat_o == 32'h1a6b)
    else $error("error code wrong");
  unmapped_zero_a: assert property (rd_req && adr_i == 6'h30 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  pulse_high_a: assert property ($rose(pulse_out_o[0]) |->
    pulse_out_o[0] [*8] ##1 pulse_out_o[0] ##1 pulse_out_o[0] ##1 !pulse_out_o[0])
    else $error("pulse high width");
  pulse_low_a: assert property ($fell(pulse_out_o[0]) |->
    !pulse_out_o[0] [*8] ##1 !pulse_out_o[0] ##1 !pulse_out_o[0]) else $error("pulse gap");
  // direction may move only outside a pulse
  dir_hold_a: assert property (
    ($past(pulse_out_o) & pulse_out_o & (dir_out_o ^ $past(dir_out_o))) == 4'h0)
    else $error("direction moved in pulse");
  rst_quiet_a: assert property (disable iff (1'b0)
    rst_i |=> pulse_out_o == 4'h0 && !irq_o && !ack_o) else $error("reset not quiet");
  cover property ($rose(pulse_out_o[3]));
  cover property (pulse_out_o[1] && !dir_out_o[1]);
  cover property ($rose(irq_o));
endmodule
bind ips_top ips_check u_check (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .pulse_out_o(pulse_out_o),
  .dir_out_o(dir_out_o), .irq_o(irq_o));

// ==== bench/interrupt_positioning_input_select_bench.sv ====
`timescale 1ns/10ps
// ****
// bench top
// ****
module interrupt_positioning_input_select_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [5:0]  adr_i = 6'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [7:0]  ext_input_i = 8'h00;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire  [3:0]  pulse_out_o;
  wire  [3:0]  dir_out_o;
  wire         irq_o;
  int          error_cnt = 0;
  int          checked = 0;
  int          p0;
  logic [3:0][31:0] pos;
  logic [31:0] q;

  ips_top #(.NCH(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_input_i(ext_input_i), .pulse_out_o(pulse_out_o), .dir_out_o(dir_out_o),
    .irq_o(irq_o));
  ips_drive drv (.clk_i(clk_i), .pulse_i(pulse_out_o), .dir_i(dir_out_o), .pos_o(pos));

  // 20 MHz
  initial forever #25 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic cycle; ack and data are taken at the same edge
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) chk("ack", 1, ack_o);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic run(input logic [1:0] ch, input logic [15:0] cnt);
    bus(1, 4'h5, {14'h0, ch, cnt});
    bus(1, 4'h4, 32'h1 << ch);
  endtask
  // poll status until no channel is busy, bounded
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(0, 4'h6, 0);
      n++;
    end while (q[3:0] !== 4'h0 && n < 100);
    chk("busy", 0, q[3:0]);
  endtask
  task automatic s_regs;
    bus(0, 4'h1, 0);
    chk("sel reset", 32'hffff, q);
    bus(0, 4'hc, 0);
    chk("unmapped", 0, q);
    bus(0, 4'hb, 0);
    chk("errcode", 32'h1a6b, q);
    bus(1, 4'h1, 32'h1234);
    bus(0, 4'h1, 0);
    chk("sel rw", 32'h1234, q);
    bus(1, 4'h1, 32'hffff);
  endtask
  task automatic s_fixed;
    bus(1, 4'h0, 0);
    bus(1, 4'h9, 1);
    p0 = pos[0];
    run(0, 16'h0003);
    repeat (20) @(posedge clk_i);
    chk("no trigger", p0, pos[0]);
    ext_input_i <= 8'h01;
    idle;
    ext_input_i <= 8'h00;
    chk("fwd count", p0 + 3, pos[0]);
    chk("fwd dir", 1, dir_out_o[0]);
    chk("complete", 1, q[8]);
    chk("irq", 1, irq_o);
    bus(1, 4'h9, 0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 0, irq_o);
    bus(1, 4'h8, 1);
    bus(1, 4'h9, 1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 0, irq_o);
  endtask
  // abort while waiting for the trigger: no completion, position kept
  task automatic s_abort;
    bus(1, 4'h0, 0);
    p0 = pos[0];
    run(0, 16'h0005);
    bus(0, 4'h6, 0);
    chk("armed", 1, q[0]);
    bus(1, 4'h4, 32'h100);
    bus(0, 4'h6, 0);
    chk("abort busy", 0, q[3:0]);
    chk("abort complete", 0, q[8]);
    bus(0, 4'ha, 0);
    chk("pos reg", p0, q);
  endtask
  task automatic s_select;
    bus(1, 4'h0, 1);
    bus(1, 4'h1, 32'hff5f);
    bus(1, 4'h2, 32'h2);
    ext_input_i <= 8'h20;
    p0 = pos[1];
    run(1, 16'hfffe);
    repeat (20) @(posedge clk_i);
    chk("held", p0, pos[1]);
    ext_input_i <= 8'h00;
    idle;
    chk("rev count", p0 - 2, pos[1]);
    chk("rev dir", 0, dir_out_o[1]);
    bus(1, 4'h2, 0);
  endtask
  task automatic s_user;
    bus(1, 4'h1, 32'hf8ff);
    bus(1, 4'h2, 32'h4);
    p0 = pos[2];
    run(2, 16'h0001);
    repeat (20) @(posedge clk_i);
    chk("user wait", p0, pos[2]);
    bus(1, 4'h3, 32'h4);
    idle;
    chk("user count", p0 + 1, pos[2]);
    bus(1, 4'h3, 0);
    bus(1, 4'h2, 0);
  endtask
  task automatic s_illegal;
    ext_input_i <= 8'hff;
    p0 = pos[0];
    for (int d = 9; d < 15; d++) begin
      bus(1, 4'h1, 32'hfff0 | d);
      run(0, 16'h0001);
      bus(0, 4'h6, 0);
      chk("err flag", 2'b10, {q[4], q[0]});
      bus(1, 4'h8, 32'hf2);
    end
    repeat (30) @(posedge clk_i);
    chk("no pulses", p0, pos[0]);
    bus(1, 4'h0, 0);
    run(3, 16'h0001);
    bus(0, 4'h6, 0);
    chk("ch3 refused", 1, q[7]);
    bus(1, 4'h8, 32'hf2);
    bus(1, 4'h0, 2);
    p0 = pos[3];
    run(3, 16'h0001);
    idle;
    chk("ch3 count", p0 + 1, pos[3]);
    chk("ch3 dir", 1, dir_out_o[3]);
    ext_input_i <= 8'h00;
  endtask
  task automatic final_report;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs;
    s_fixed;
    s_abort;
    s_select;
    s_user;
    s_illegal;
    final_report;
  end
  // watchdog: whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report;
  end
endmodule
